// ==== diot_axil.sv ====
// AXI4-Lite slave front end for the discrete I/O test override registers
`timescale 1ns/1ps
module diot_axil
  import diot_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [DIOT_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DIOT_DW-1:0] s_axi_wdata,
  input wire logic [DIOT_SW-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [DIOT_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DIOT_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register file side
  output logic wr_valid,
  output diot_wreq_s wr_req,
  input wire logic wr_ok,
  output logic [DIOT_AW-1:0] rd_addr,
  input wire diot_rans_s rd_ans
);

  logic aw_full, next_aw_full, w_full, next_w_full;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [DIOT_DW-1:0] next_rdata;
  diot_wreq_s held, next_held;
  logic aw_fire, w_fire, ar_fire, do_write;

  // Read address goes straight to the decoder
  assign rd_addr = s_axi_araddr;
  assign wr_valid = do_write;
  assign wr_req = held;

  // Address and data are caught in either order; write fires once both are held
  always_comb
  begin
    aw_fire = s_axi_awvalid & s_axi_awready;
    w_fire = s_axi_wvalid & s_axi_wready;
    ar_fire = s_axi_arvalid & s_axi_arready;
    do_write = aw_full & w_full & ~s_axi_bvalid;
    next_held = held;
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (aw_fire)
    begin
      next_held.addr = s_axi_awaddr;
      next_aw_full = 1'b1;
    end
    if (w_fire)
    begin
      next_held.data = s_axi_wdata;
      next_held.strb = s_axi_wstrb;
      next_w_full = 1'b1;
    end
    if (s_axi_bvalid & s_axi_bready)
      next_bvalid = 1'b0;
    if (do_write)
    begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    next_awready = ~next_aw_full & ~next_bvalid;
    next_wready = ~next_w_full & ~next_bvalid;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid & s_axi_rready)
      next_rvalid = 1'b0;
    if (ar_fire)
    begin
      next_rvalid = 1'b1;
      next_rdata = rd_ans.data;
      next_rresp = rd_ans.ok ? RESP_OKAY : RESP_SLVERR;
    end
    next_arready = ~next_rvalid;
  end

  // Bus state registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      held <= '0;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      held <= next_held;
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

endmodule // diot_axil

// ==== diot_field.sv ====
// Field contact model feeding the sensed contacts
`timescale 1ns/1ps
module diot_field
  import diot_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Requested contact positions
  input wire logic [DIOT_CH-1:0] sense_set,
  // Sensed contacts, high closed
  output logic [DIOT_CH-1:0] contact_in
);
  // Contacts settle just after the edge, never mid-cycle
  always_ff @(posedge aclk) contact_in <= sense_set;
endmodule // diot_field

// ==== diot_pkg.sv ====
// Shared constants, register map and types for the discrete I/O test override block
package diot_pkg;

  // Channel counts and field layout
  localparam int DIOT_CH = 27;
  localparam int DIOT_FIELD_W = 2;
  localparam int DIOT_FIELDS_PER_WORD = 16;
  localparam int DIOT_FIELDS_PER_LANE = 4;
  localparam int DIOT_AW = 8;
  localparam int DIOT_DW = 32;
  localparam int DIOT_SW = 4;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IN_PEND_LO = 8'h08;
  localparam logic [7:0] ADDR_IN_PEND_HI = 8'h0c;
  localparam logic [7:0] ADDR_OUT_PEND_LO = 8'h10;
  localparam logic [7:0] ADDR_OUT_PEND_HI = 8'h14;
  localparam logic [7:0] ADDR_OUT_VIEW = 8'h18;
  localparam logic [7:0] ADDR_IN_VIEW = 8'h1c;
  localparam logic [7:0] ADDR_IN_ACT_LO = 8'h20;
  localparam logic [7:0] ADDR_IN_ACT_HI = 8'h24;
  localparam logic [7:0] ADDR_OUT_ACT_LO = 8'h28;
  localparam logic [7:0] ADDR_OUT_ACT_HI = 8'h2c;

  // Control and status bit positions
  localparam int CTRL_TEST_BIT = 0;
  localparam int CTRL_MAINS50_BIT = 1;
  localparam int CTRL_APPLY_BIT = 2;
  localparam int CTRL_REFRESH_BIT = 3;
  localparam int STAT_TEST_BIT = 0;
  localparam int STAT_IN_FORCED_BIT = 1;
  localparam int STAT_OUT_FORCED_BIT = 2;
  localparam int STAT_MAINS50_BIT = 3;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Half mains cycle timing, times in microseconds, clock period in picoseconds
  localparam longint HALF60_US = 8333;
  localparam longint HALF50_US = 10000;
  localparam longint PS_PER_US = 1000000;
  localparam longint CLK_PERIOD_PS = 5000;
  localparam int HALF60_CYC = int'((HALF60_US * PS_PER_US) / CLK_PERIOD_PS);
  localparam int HALF50_CYC = int'((HALF50_US * PS_PER_US) / CLK_PERIOD_PS);
  localparam int HALF_CNT_W = 22;

  // Input force codes; the top code is reserved and acts as unforced
  typedef enum logic [1:0] {
    IN_FORCE_NONE = 2'h0,
    IN_FORCE_OPEN = 2'h1,
    IN_FORCE_CLOSED = 2'h2
  } diot_in_force_e;

  // Output force codes
  typedef enum logic [1:0] {
    OUT_FORCE_NONE = 2'h0,
    OUT_FORCE_ENERGIZE = 2'h1,
    OUT_FORCE_DEENERGIZE = 2'h2,
    OUT_FORCE_FREEZE = 2'h3
  } diot_out_force_e;

  // One register write as handed from the bus slave to the register file
  typedef struct packed {
    logic [DIOT_AW-1:0] addr;
    logic [DIOT_DW-1:0] data;
    logic [DIOT_SW-1:0] strb;
  } diot_wreq_s;

  // One register read answer
  typedef struct packed {
    logic [DIOT_DW-1:0] data;
    logic ok;
  } diot_rans_s;

endpackage

// ==== diot_top.sv ====
// Discrete contact I/O test override with half-cycle service and state snapshots
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
// Functional notes
// (RULE1) One test enable arms overrides on inputs and outputs until cleared or reset.
// (RULE2) Each input has three force codes; unforced passes the sensed contact.
// (RULE3) In test mode forced open reads low, forced closed reads high.
// (RULE4) Input force lasts until rewritten, test disabled, or reset.
// (RULE5) Each output has four force codes; unforced drives the computed value.
// (RULE6) In test mode energize drives high, de-energize drives low.
// (RULE7) Freeze holds the output's current state, ignoring computed transitions.
// (RULE8) Output force lasts until rewritten, test disabled, or reset.
// (RULE9) Edited force codes act only after an explicit apply command.
// (RULE10) Present state of every output is readable while running.
// (RULE11) Output state read is a snapshot updated only on refresh.
// (RULE12) Inputs read and outputs written once per half mains cycle.
// (RULE13) Normal output: on while operate true, sealed in while hold-in true.
// (RULE14) Reset clears test enable and every force code to unforced.
module diot_top
  import diot_pkg::*;
#(
  parameter int HALF60_CYCLES = HALF60_CYC,
  parameter int HALF50_CYCLES = HALF50_CYC
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [DIOT_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DIOT_DW-1:0] s_axi_wdata,
  input wire logic [DIOT_SW-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [DIOT_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DIOT_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Field contacts and logic engine operands
  input wire logic [DIOT_CH-1:0] contact_in,
  input wire logic [DIOT_CH-1:0] operate_operand,
  input wire logic [DIOT_CH-1:0] seal_in_operand,
  // Image to the logic engine and coil drives
  output logic [DIOT_CH-1:0] input_image,
  output logic [DIOT_CH-1:0] contact_out,
  output logic service_tick
);

  logic wr_valid, wr_ok;
  diot_wreq_s wr_req;
  logic [DIOT_AW-1:0] rd_addr;
  diot_rans_s rd_ans;

  logic test_en, next_test_en, mains50, next_mains50;
  logic apply_hit, refresh_hit;
  logic [DIOT_CH-1:0][DIOT_FIELD_W-1:0] in_pend, next_in_pend, out_pend, next_out_pend;
  logic [DIOT_CH-1:0][DIOT_FIELD_W-1:0] in_act, next_in_act, out_act, next_out_act;
  logic [DIOT_CH-1:0] output_state_view, next_output_state_view;
  logic [DIOT_CH-1:0] input_state_view, next_input_state_view;
  logic [DIOT_CH-1:0] sealed, next_sealed, normal_out;
  logic [DIOT_CH-1:0] forced_in, forced_out, next_input_image, next_contact_out;
  logic [HALF_CNT_W-1:0] cnt, next_cnt, cnt_last;
  logic tick, next_service_tick;

  // Bus slave
  diot_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_valid(wr_valid),
    .wr_req(wr_req),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_ans(rd_ans)
  );

  // Register writes, apply and refresh commands
  always_comb
  begin
    next_test_en = test_en;
    next_mains50 = mains50;
    next_in_pend = in_pend;
    next_out_pend = out_pend;
    apply_hit = 1'b0;
    refresh_hit = 1'b0;
    wr_ok = 1'b1;
    if (wr_valid)
    begin
      case (wr_req.addr)
        ADDR_CTRL:
        begin
          if (wr_req.strb[0])
          begin
            next_test_en = wr_req.data[CTRL_TEST_BIT]; // [RULE1]
            next_mains50 = wr_req.data[CTRL_MAINS50_BIT];
            apply_hit = wr_req.data[CTRL_APPLY_BIT];
            refresh_hit = wr_req.data[CTRL_REFRESH_BIT];
          end
        end
        ADDR_IN_PEND_LO, ADDR_IN_PEND_HI:
        begin
          for (int c = 0; c < DIOT_CH; c++)
          begin
            if ((c / DIOT_FIELDS_PER_WORD) == int'(wr_req.addr == ADDR_IN_PEND_HI) &&
                wr_req.strb[(c % DIOT_FIELDS_PER_WORD) / DIOT_FIELDS_PER_LANE])
              next_in_pend[c] = wr_req.data[(c % DIOT_FIELDS_PER_WORD) * DIOT_FIELD_W +: DIOT_FIELD_W];
          end
        end
        ADDR_OUT_PEND_LO, ADDR_OUT_PEND_HI:
        begin
          for (int c = 0; c < DIOT_CH; c++)
          begin
            if ((c / DIOT_FIELDS_PER_WORD) == int'(wr_req.addr == ADDR_OUT_PEND_HI) &&
                wr_req.strb[(c % DIOT_FIELDS_PER_WORD) / DIOT_FIELDS_PER_LANE])
              next_out_pend[c] = wr_req.data[(c % DIOT_FIELDS_PER_WORD) * DIOT_FIELD_W +: DIOT_FIELD_W];
          end
        end
        ADDR_STATUS, ADDR_OUT_VIEW, ADDR_IN_VIEW, ADDR_IN_ACT_LO, ADDR_IN_ACT_HI,
        ADDR_OUT_ACT_LO, ADDR_OUT_ACT_HI:
          wr_ok = 1'b1;
        default:
          wr_ok = 1'b0;
      endcase
    end
  end

  // Active forces: copied on apply, dropped when test mode ends
  always_comb
  begin
    next_in_act = in_act;
    next_out_act = out_act;
    if (apply_hit)
    begin
      next_in_act = in_pend; // [RULE9]
      next_out_act = out_pend; // [RULE9]
      if (wr_valid && wr_req.addr == ADDR_CTRL)
      begin
        next_in_act = next_in_pend;
        next_out_act = next_out_pend;
      end
    end
    if (!next_test_en)
    begin
      next_in_act = '0; // [RULE4]
      next_out_act = '0; // [RULE8]
    end
  end

  // Snapshots of the presented states, taken only on refresh
  always_comb
  begin
    next_output_state_view = output_state_view;
    next_input_state_view = input_state_view;
    if (refresh_hit)
    begin
      next_output_state_view = contact_out; // [RULE11]
      next_input_state_view = input_image;
    end
  end

  // Half mains cycle service timer
  always_comb
  begin
    cnt_last = mains50 ? HALF_CNT_W'(HALF50_CYCLES - 1) : HALF_CNT_W'(HALF60_CYCLES - 1);
    tick = (cnt >= cnt_last); // [RULE12]
    next_cnt = tick ? '0 : cnt + HALF_CNT_W'(1);
    if (next_mains50 != mains50)
      next_cnt = '0;
    next_service_tick = tick;
  end

  // Per-channel force decode and output seal-in
  for (genvar c = 0; c < DIOT_CH; c++)
  begin : g_ch
    always_comb
    begin
      normal_out[c] = operate_operand[c] | (seal_in_operand[c] & sealed[c]); // [RULE13]
      forced_in[c] = contact_in[c]; // [RULE2]
      if (test_en)
      begin
        case (in_act[c])
          IN_FORCE_OPEN: forced_in[c] = 1'b0; // [RULE3]
          IN_FORCE_CLOSED: forced_in[c] = 1'b1; // [RULE3]
          default: forced_in[c] = contact_in[c];
        endcase
      end
      forced_out[c] = normal_out[c]; // [RULE5]
      if (test_en)
      begin
        unique case (out_act[c])
          OUT_FORCE_NONE: forced_out[c] = normal_out[c];
          OUT_FORCE_ENERGIZE: forced_out[c] = 1'b1; // [RULE6]
          OUT_FORCE_DEENERGIZE: forced_out[c] = 1'b0; // [RULE6]
          OUT_FORCE_FREEZE: forced_out[c] = contact_out[c]; // [RULE7]
        endcase
      end
    end
  end

  // Inputs sampled and coils updated together on each service tick
  always_comb
  begin
    next_input_image = tick ? forced_in : input_image; // [RULE12]
    next_contact_out = tick ? forced_out : contact_out; // [RULE12]
    next_sealed = tick ? normal_out : sealed;
  end

  // Register read decode
  always_comb
  begin
    rd_ans.data = '0;
    rd_ans.ok = 1'b1;
    case (rd_addr)
      ADDR_CTRL:
      begin
        rd_ans.data[CTRL_TEST_BIT] = test_en;
        rd_ans.data[CTRL_MAINS50_BIT] = mains50;
      end
      ADDR_STATUS:
      begin
        rd_ans.data[STAT_TEST_BIT] = test_en;
        rd_ans.data[STAT_IN_FORCED_BIT] = |in_act;
        rd_ans.data[STAT_OUT_FORCED_BIT] = |out_act;
        rd_ans.data[STAT_MAINS50_BIT] = mains50;
      end
      ADDR_IN_PEND_LO: rd_ans.data = in_pend[DIOT_FIELDS_PER_WORD-1:0];
      ADDR_IN_PEND_HI: rd_ans.data = DIOT_DW'(in_pend[DIOT_CH-1:DIOT_FIELDS_PER_WORD]);
      ADDR_OUT_PEND_LO: rd_ans.data = out_pend[DIOT_FIELDS_PER_WORD-1:0];
      ADDR_OUT_PEND_HI: rd_ans.data = DIOT_DW'(out_pend[DIOT_CH-1:DIOT_FIELDS_PER_WORD]);
      ADDR_OUT_VIEW: rd_ans.data = DIOT_DW'(output_state_view); // [RULE10]
      ADDR_IN_VIEW: rd_ans.data = DIOT_DW'(input_state_view);
      ADDR_IN_ACT_LO: rd_ans.data = in_act[DIOT_FIELDS_PER_WORD-1:0];
      ADDR_IN_ACT_HI: rd_ans.data = DIOT_DW'(in_act[DIOT_CH-1:DIOT_FIELDS_PER_WORD]);
      ADDR_OUT_ACT_LO: rd_ans.data = out_act[DIOT_FIELDS_PER_WORD-1:0];
      ADDR_OUT_ACT_HI: rd_ans.data = DIOT_DW'(out_act[DIOT_CH-1:DIOT_FIELDS_PER_WORD]);
      default: rd_ans.ok = 1'b0;
    endcase
  end

  // State registers; reset leaves test mode off and every force unforced
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      test_en <= 1'b0; // [RULE14]
      mains50 <= 1'b0;
      in_pend <= '0;
      out_pend <= '0;
      in_act <= '0; // [RULE14]
      out_act <= '0; // [RULE14]
      output_state_view <= '0;
      input_state_view <= '0;
      sealed <= '0;
      input_image <= '0;
      contact_out <= '0;
      cnt <= '0;
      service_tick <= 1'b0;
    end
    else
    begin
      test_en <= next_test_en;
      mains50 <= next_mains50;
      in_pend <= next_in_pend;
      out_pend <= next_out_pend;
      in_act <= next_in_act;
      out_act <= next_out_act;
      output_state_view <= next_output_state_view;
      input_state_view <= next_input_state_view;
      sealed <= next_sealed;
      input_image <= next_input_image;
      contact_out <= next_contact_out;
      cnt <= next_cnt;
      service_tick <= next_service_tick;
    end
  end

endmodule // diot_top

// ==== diot_top_assertions.sv ====
// Port level checks for the discrete I/O test override block
`timescale 1ns/1ps
module diot_top_assertions
  import diot_pkg::*;
#(
  parameter int HALF60_CYCLES = 20,
  parameter int HALF50_CYCLES = 24
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [DIOT_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DIOT_DW-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Images and service pulse
  input wire logic [DIOT_CH-1:0] input_image,
  input wire logic [DIOT_CH-1:0] contact_out,
  input wire logic service_tick
);
  localparam int MIN_GAP = (HALF60_CYCLES < HALF50_CYCLES ? HALF60_CYCLES : HALF50_CYCLES) - 1;
  logic [21:0] gap;
  logic [21:0] next_gap;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Quiet cycles since the last service pulse
  always_comb
  begin
    next_gap = service_tick ? 22'h0 : gap + 22'h1;
  end
  always_ff @(posedge aclk)
  begin
    gap <= !aresetn ? 22'h0 : next_gap;
  end

  // Handshake steps
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_tick_pulse: assert property (service_tick |=> !service_tick)
    else $error("service pulse longer than one cycle");
  a_tick_spacing: assert property (service_tick |-> gap >= MIN_GAP)
    else $error("service pulses too close");
  a_coil_at_tick: assert property ($changed(contact_out) |-> service_tick)
    else $error("coil drive moved between service instants");
  a_image_at_tick: assert property ($changed(input_image) |-> service_tick)
    else $error("input image moved between service instants");
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write got no answer");
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_read_answer: assert property (s_rd_taken |-> ##[1:2] s_axi_rvalid)
    else $error("read got no answer");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  a_unmapped_read: assert property ((s_rd_taken ##0 s_axi_araddr == 8'h30) |->
    ##[1:2] (s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0))
    else $error("unmapped read not refused");
endmodule // diot_top_assertions

bind diot_top diot_top_assertions #(.HALF60_CYCLES(HALF60_CYCLES), .HALF50_CYCLES(HALF50_CYCLES)) u_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .input_image, .contact_out, .service_tick
);

// ==== tb_top.sv ====
// Self-checking bench for the discrete I/O test override block
`timescale 1ns/1ps
module tb_top
  import diot_pkg::*;
;
  logic aclk, aresetn, service_tick;
  logic [DIOT_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DIOT_DW-1:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [DIOT_SW-1:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [DIOT_CH-1:0] contact_in, operate_operand, seal_in_operand, input_image, contact_out, sense_set;
  int n_mismatch, check_count, gap;
  localparam logic [26:0] SENSE = 27'h5a5a5a5;
  localparam logic [26:0] IMG_F = (SENSE & ~27'h10003) | 27'h10002;

  // Device under test with short half cycles
  diot_top #(.HALF60_CYCLES(20), .HALF50_CYCLES(24)) uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .contact_in, .operate_operand, .seal_in_operand, .input_image, .contact_out, .service_tick
  );
  diot_field fld (.aclk, .sense_set, .contact_in);

  // 200 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tmo;
    n_mismatch++;
    report_and_stop();
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (n > 50) tmo();
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  // One bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (n > 50) tmo();
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask

  task automatic wc(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask

  // Edges until a service pulse is seen
  task automatic wtick(output int c);
    c = 0;
    do
    begin
      @(posedge aclk);
      c++;
      if (c > 100) tmo();
    end
    while (service_tick !== 1'b1);
  endtask

  task automatic tick2;
    int c;
    wtick(c);
    wtick(c);
  endtask

  // Main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {operate_operand, seal_in_operand, sense_set} = '0;
    n_mismatch = 0;
    check_count = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(ADDR_STATUS, 32'h0);
    rd(8'h30, rdat, resp);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(8'h30, 32'hffffffff, resp);
    chk(32'(resp), 32'(RESP_SLVERR));
    // Normal operate and seal-in
    sense_set <= SENSE;
    operate_operand <= 27'h5;
    tick2();
    chk(32'(input_image), 32'(SENSE));
    chk(32'(contact_out), 32'h5);
    operate_operand <= 27'h0;
    seal_in_operand <= 27'h4;
    tick2();
    chk(32'(contact_out), 32'h4);
    seal_in_operand <= 27'h0;
    tick2();
    chk(32'(contact_out), 32'h0);
    // Input forces: open, closed, reserved, closed on the upper word
    wc(ADDR_IN_PEND_LO, 32'h39);
    wc(ADDR_IN_PEND_HI, 32'h2);
    wc(ADDR_CTRL, 32'h1);
    tick2();
    chk(32'(input_image), 32'(SENSE));
    wc(ADDR_CTRL, 32'h5);
    tick2();
    chk(32'(input_image), 32'(IMG_F));
    rdc(ADDR_IN_ACT_LO, 32'h39);
    rdc(ADDR_STATUS, 32'h3);
    // Output forces: energize, de-energize, freeze, unforced
    operate_operand <= 27'h6;
    wc(ADDR_OUT_PEND_LO, 32'h39);
    wc(ADDR_OUT_PEND_HI, 32'h1);
    tick2();
    chk(32'(contact_out), 32'h6);
    operate_operand <= 27'h8;
    wc(ADDR_CTRL, 32'h5);
    tick2();
    chk(32'(contact_out), 32'h1000d);
    chk(32'(input_image), 32'(IMG_F));
    rdc(ADDR_STATUS, 32'h7);
    rdc(ADDR_IN_ACT_HI, 32'h2);
    rdc(ADDR_OUT_ACT_HI, 32'h1);
    // Snapshots follow refresh only
    wc(ADDR_CTRL, 32'h9);
    rdc(ADDR_OUT_VIEW, 32'h1000d);
    rdc(ADDR_IN_VIEW, 32'(IMG_F));
    wc(ADDR_CTRL, 32'h0);
    rdc(ADDR_OUT_ACT_LO, 32'h0);
    rdc(ADDR_IN_ACT_LO, 32'h0);
    tick2();
    chk(32'(contact_out), 32'h8);
    chk(32'(input_image), 32'(SENSE));
    rdc(ADDR_OUT_VIEW, 32'h1000d);
    wc(ADDR_CTRL, 32'h8);
    rdc(ADDR_OUT_VIEW, 32'h8);
    // Half cycle period at both mains rates
    tick2();
    wtick(gap);
    chk(32'(gap), 32'h14);
    wc(ADDR_CTRL, 32'h2);
    tick2();
    wtick(gap);
    chk(32'(gap), 32'h18);
    rdc(ADDR_STATUS, 32'h8);
    // Restart in mid-run with forces active
    wc(ADDR_CTRL, 32'h7);
    rdc(ADDR_STATUS, 32'hf);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'(contact_out), 32'h0);
    rdc(ADDR_STATUS, 32'h0);
    rdc(ADDR_OUT_PEND_LO, 32'h0);
    report_and_stop();
  end
endmodule // tb_top
